// ### qcc_top.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// ****************************************************************
// Quadrature counter control and compare logic
// ****************************************************************
module qcc_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    output logic position_match_flag,
    output logic shared_match_flag,
    output logic both_match_flag
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    qcc_edge_if a_ev();  // Phase A pin events
    qcc_edge_if b_ev();  // Phase B pin events
    qcc_edge_if z_ev();  // Index pin events

    qcc_sync_edge u_sync_a (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(phase_a_input),
        .ev(a_ev)
    );
    qcc_sync_edge u_sync_b (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(phase_b_input),
        .ev(b_ev)
    );
    qcc_sync_edge u_sync_z (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin(index_input),
        .ev(z_ev)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    logic [15:0] pos_reg, pos_next;          // Position counter
    logic [15:0] rev_reg, rev_next;          // Revolution counter
    logic [15:0] pcmp_reg, pcmp_next;        // Position compare
    logic [15:0] scmp_reg, scmp_next;        // Shared compare
    logic [15:0] ctrl_reg, ctrl_next;        // Control bits
    logic [15:0] max_reg, max_next;          // Maximum position
    logic pmf_reg, pmf_next;                 // Position match flag
    logic smf_reg, smf_next;                 // Shared match flag
    logic bmf_reg, bmf_next;                 // Both match flag
    logic dir_reg, dir_next;                 // Last direction, 1 is up
    logic dir_known_reg, dir_known_next;     // A counted step seen since enable
    logic [31:0] prdata_reg, prdata_next;    // Read data
    logic pready_reg, pready_next;           // Access-phase answer
    logic pslverr_reg, pslverr_next;         // Error answer

    // ****************************************************************
    // Control decode
    // ****************************************************************
    qcc_pkg::qcc_pos_mode_t pos_mode;
    qcc_pkg::qcc_rev_mode_t rev_mode;
    logic swap, target;
    logic gate_mode, stop;
    logic [1:0] aedge_sel, bedge_sel, zedge_sel;
    assign pos_mode = qcc_pkg::qcc_pos_mode_t'(ctrl_reg[qcc_pkg::QCC_POS_LSB +: 2]);
    assign rev_mode = qcc_pkg::qcc_rev_mode_t'(ctrl_reg[qcc_pkg::QCC_REV_LSB +: 2]);
    assign swap = ctrl_reg[qcc_pkg::QCC_SWAP_BIT];
    assign target = ctrl_reg[qcc_pkg::QCC_TARGET_BIT];
    assign gate_mode = ctrl_reg[qcc_pkg::QCC_GATE_BIT];
    assign stop = ctrl_reg[qcc_pkg::QCC_STOP_BIT];
    assign aedge_sel = ctrl_reg[qcc_pkg::QCC_AEDGE_LSB +: 2];
    assign bedge_sel = ctrl_reg[qcc_pkg::QCC_BEDGE_LSB +: 2];
    assign zedge_sel = ctrl_reg[qcc_pkg::QCC_ZEDGE_LSB +: 2];

    // ****************************************************************
    // Counter inputs after swap
    // ****************************************************************
    logic ain_lvl, ain_rise, ain_fall;
    logic bin_lvl, bin_rise, bin_fall;
    logic ain_act, bin_act, z_act, gate_ok;
    always_comb begin
        // Pin exchange
        ain_lvl = swap ? b_ev.level : a_ev.level;
        ain_rise = swap ? b_ev.rise : a_ev.rise;
        ain_fall = swap ? b_ev.fall : a_ev.fall;
        bin_lvl = swap ? a_ev.level : b_ev.level;
        bin_rise = swap ? a_ev.rise : b_ev.rise;
        bin_fall = swap ? a_ev.fall : b_ev.fall;
        // Phase edge choice
        ain_act = (aedge_sel[1] & ain_rise) | (aedge_sel[0] & ain_fall);
        bin_act = (bedge_sel[1] & bin_rise) | (bedge_sel[0] & bin_fall);
        // Index edge choice
        z_act = ~gate_mode & ((zedge_sel[1] & z_ev.rise) | (zedge_sel[0] & z_ev.fall));
        // Gate level, codes 00 and 11 detect no level
        unique case (zedge_sel)
            2'b01: gate_ok = ~z_ev.level;
            2'b10: gate_ok = z_ev.level;
            default: gate_ok = 1'b0;
        endcase
        if (!gate_mode) begin
            gate_ok = 1'b1;
        end
    end

    // ****************************************************************
    // Step request and direction
    // ****************************************************************
    logic step, step_up;
    always_comb begin
        step = 1'b0;
        step_up = 1'b0;
        unique case (pos_mode)
            qcc_pkg::QCC_POS_OFF: begin
                step = 1'b0;  // Disabled
            end
            qcc_pkg::QCC_POS_UPDN: begin
                // A edge up, B edge down; both together cancel
                step = ain_act ^ bin_act;
                step_up = ain_act;
            end
            qcc_pkg::QCC_POS_PHASE: begin
                // A edge while B level differs means A leads
                if (ain_act) begin
                    step = 1'b1;
                    step_up = ain_rise ? ~bin_lvl : bin_lvl;
                end else if (bin_act) begin
                    step = 1'b1;
                    step_up = bin_rise ? ain_lvl : ~ain_lvl;
                end
            end
            qcc_pkg::QCC_POS_DIR: begin
                // B edge steps, A level directs
                step = bin_act;
                step_up = ain_lvl;
            end
        endcase
        // Stop bit and gate level
        if (stop || !gate_ok) begin
            step = 1'b0;
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic wr_en, rd_en, hit;
    logic [15:0] wdata16;
    always_comb begin
        wr_en = psel & penable & pwrite & ~pready_reg;
        rd_en = psel & penable & ~pwrite & ~pready_reg;
        wdata16 = pwdata[15:0];
        unique case (paddr)
            qcc_pkg::QCC_POS_COUNT_OFS, qcc_pkg::QCC_REV_COUNT_OFS,
            qcc_pkg::QCC_POS_CMP_OFS, qcc_pkg::QCC_SHR_CMP_OFS,
            qcc_pkg::QCC_CTRL_OFS, qcc_pkg::QCC_MAX_POS_OFS,
            qcc_pkg::QCC_STATUS_OFS: hit = (paddr[1:0] == 2'b00);
            default: hit = 1'b0;
        endcase
    end

    // Halfword writes need both low byte lanes
    logic lanes_ok;
    assign lanes_ok = (pstrb[1:0] == 2'b11);

    // ****************************************************************
    // Counter and register next state
    // ****************************************************************
    logic wrap_ev;
    logic rev_step, rev_up;
    logic [15:0] pos_mid;
    always_comb begin
        pos_next = pos_reg;
        rev_next = rev_reg;
        pcmp_next = pcmp_reg;
        scmp_next = scmp_reg;
        ctrl_next = ctrl_reg;
        max_next = max_reg;
        dir_next = dir_reg;
        dir_known_next = dir_known_reg;
        wrap_ev = 1'b0;
        rev_step = 1'b0;
        rev_up = 1'b0;
        pos_mid = pos_reg;
        // Position stepping with wrap
        if (step) begin
            dir_next = step_up;
            dir_known_next = 1'b1;
            if (step_up) begin
                if (pos_reg == max_reg) begin
                    pos_mid = qcc_pkg::QCC_COUNT_RST;
                    wrap_ev = 1'b1;
                end else begin
                    pos_mid = pos_reg + 16'h0001;
                end
            end else begin
                if (pos_reg == 16'h0000) begin
                    pos_mid = max_reg;
                    wrap_ev = 1'b1;
                end else begin
                    pos_mid = pos_reg - 16'h0001;
                end
            end
        end
        pos_next = pos_mid;

        // Revolution events by mode
        if (wrap_ev && rev_mode[1]) begin
            rev_step = 1'b1;
            rev_up = step_up;
        end
        // Index clears position in modes 00, 01, 11
        if (z_act && rev_mode != qcc_pkg::QCC_REV_WRAP) begin
            pos_next = qcc_pkg::QCC_COUNT_RST;
            // No known direction: revolution untouched
            if (rev_mode[0] && dir_known_reg && !rev_step) begin
                rev_step = 1'b1;
                rev_up = dir_reg;
            end
        end
        if (rev_step) begin
            rev_next = rev_up ? rev_reg + 16'h0001 : rev_reg - 16'h0001;
        end
        // Leaving or entering disabled position mode forgets direction
        if (pos_mode == qcc_pkg::QCC_POS_OFF) begin
            dir_known_next = 1'b0;
        end

        // Register writes
        if (wr_en && hit && lanes_ok) begin
            unique case (paddr)
                qcc_pkg::QCC_REV_COUNT_OFS: begin
                    // Only while revolution counter disabled
                    if (rev_mode == qcc_pkg::QCC_REV_OFF) begin
                        rev_next = wdata16;
                    end
                end
                qcc_pkg::QCC_POS_CMP_OFS: pcmp_next = wdata16;
                qcc_pkg::QCC_SHR_CMP_OFS: scmp_next = wdata16;
                qcc_pkg::QCC_CTRL_OFS: ctrl_next = wdata16;
                qcc_pkg::QCC_MAX_POS_OFS: max_next = wdata16;
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    // ****************************************************************
    // Compare flags
    // ****************************************************************
    logic pm_hit, sm_hit, bm_hit, clr_ok;
    logic [2:0] clr_bits;
    always_comb begin
        // Evaluated against the registered counters each clock
        pm_hit = (pos_reg == pcmp_reg);
        sm_hit = target ? (rev_reg == scmp_reg) : (pos_reg == scmp_reg);
        bm_hit = pm_hit & (rev_reg == scmp_reg);
        clr_ok = wr_en & hit & (paddr == qcc_pkg::QCC_STATUS_OFS) & pstrb[0];
        clr_bits = clr_ok ? pwdata[2:0] : 3'h0;
        // Set wins over clear; sticky otherwise
        pmf_next = pm_hit | (pmf_reg & ~clr_bits[qcc_pkg::QCC_PMF_BIT]);
        smf_next = sm_hit | (smf_reg & ~clr_bits[qcc_pkg::QCC_SMF_BIT]);
        bmf_next = bm_hit | (bmf_reg & ~clr_bits[qcc_pkg::QCC_BMF_BIT]);
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    always_comb begin
        prdata_next = 32'h0000_0000;
        pready_next = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & (~hit | (pwrite & ~lanes_ok & ~clr_ok)
            | (pwrite & (paddr == qcc_pkg::QCC_POS_COUNT_OFS)));
        if (rd_en && hit) begin
            unique case (paddr)
                qcc_pkg::QCC_POS_COUNT_OFS: prdata_next = {16'h0000, pos_reg};
                qcc_pkg::QCC_REV_COUNT_OFS: prdata_next = {16'h0000, rev_reg};
                qcc_pkg::QCC_POS_CMP_OFS: prdata_next = {16'h0000, pcmp_reg};
                qcc_pkg::QCC_SHR_CMP_OFS: prdata_next = {16'h0000, scmp_reg};
                qcc_pkg::QCC_CTRL_OFS: prdata_next = {16'h0000, ctrl_reg};
                qcc_pkg::QCC_MAX_POS_OFS: prdata_next = {16'h0000, max_reg};
                qcc_pkg::QCC_STATUS_OFS: prdata_next = {28'h0000000, dir_reg, bmf_reg,
                    smf_reg, pmf_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pos_reg <= qcc_pkg::QCC_COUNT_RST;
            rev_reg <= qcc_pkg::QCC_COUNT_RST;
            pcmp_reg <= qcc_pkg::QCC_COUNT_RST;
            scmp_reg <= qcc_pkg::QCC_COUNT_RST;
            ctrl_reg <= qcc_pkg::QCC_CTRL_RST;
            max_reg <= qcc_pkg::QCC_MAX_RST;
            pmf_reg <= 1'b0;
            smf_reg <= 1'b0;
            bmf_reg <= 1'b0;
            dir_reg <= 1'b0;
            dir_known_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            rev_reg <= rev_next;
            pcmp_reg <= pcmp_next;
            scmp_reg <= scmp_next;
            ctrl_reg <= ctrl_next;
            max_reg <= max_next;
            pmf_reg <= pmf_next;
            smf_reg <= smf_next;
            bmf_reg <= bmf_next;
            dir_reg <= dir_next;
            dir_known_reg <= dir_known_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign position_match_flag = pmf_reg;
    assign shared_match_flag = smf_reg;
    assign both_match_flag = bmf_reg;
endmodule // qcc_top

// ### qcc_pkg.sv
// Notes on behaviour
// - Revolution count reads live; writes only when disabled
// - Revolution count clears on reset or zero write
// - Early index edge after enable resets position
// - Position equals position compare sets flag
// - Shared compare target chosen by compare_target
// - Both counters matching sets both-match flag
// - Swap bit exchanges phase A and B pins
// - Clear mode: index edge clears position counter, except in revolution mode 10
// - Gate mode: count only at valid index level
// - Position stop bit halts counting
// - Revolution mode selects index/overflow counting events
// - Position mode 00 disables counting
// - Mode 01: A edge up, B edge down
// - Mode 10: phase lead decides direction
// - Mode 11: B edge steps, A level directs
// - Index select: off, falling/low, rising/high, both
// - Phase edge select: off, fall, rise, both
// - Underflow loads maximum; overflow loads zero
package qcc_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] QCC_POS_COUNT_OFS = 8'h00;  // Position count, read only
    localparam logic [7:0] QCC_REV_COUNT_OFS = 8'h04;  // Revolution count
    localparam logic [7:0] QCC_POS_CMP_OFS = 8'h08;    // Position compare
    localparam logic [7:0] QCC_SHR_CMP_OFS = 8'h0c;    // Shared compare
    localparam logic [7:0] QCC_CTRL_OFS = 8'h10;       // Control: low byte, edge selects
    localparam logic [7:0] QCC_MAX_POS_OFS = 8'h14;    // Maximum position
    localparam logic [7:0] QCC_STATUS_OFS = 8'h18;     // Flags, write one to clear
    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int QCC_SWAP_BIT = 7;
    localparam int QCC_TARGET_BIT = 6;
    localparam int QCC_GATE_BIT = 5;
    localparam int QCC_STOP_BIT = 4;
    localparam int QCC_REV_LSB = 2;
    localparam int QCC_POS_LSB = 0;
    localparam int QCC_AEDGE_LSB = 8;
    localparam int QCC_BEDGE_LSB = 10;
    localparam int QCC_ZEDGE_LSB = 12;
    // Status bit positions
    localparam int QCC_PMF_BIT = 0;
    localparam int QCC_SMF_BIT = 1;
    localparam int QCC_BMF_BIT = 2;
    localparam int QCC_DIR_BIT = 3;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] QCC_COUNT_RST = 16'h0000;
    localparam logic [15:0] QCC_CTRL_RST = 16'h0000;
    localparam logic [15:0] QCC_MAX_RST = 16'hffff;
    // ****************************************************************
    // Mode encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        QCC_POS_OFF = 2'b00,
        QCC_POS_UPDN = 2'b01,
        QCC_POS_PHASE = 2'b10,
        QCC_POS_DIR = 2'b11
    } qcc_pos_mode_t;
    typedef enum logic [1:0] {
        QCC_REV_OFF = 2'b00,
        QCC_REV_INDEX = 2'b01,
        QCC_REV_WRAP = 2'b10,
        QCC_REV_BOTH = 2'b11
    } qcc_rev_mode_t;
endpackage

// ### qcc_edge_if.sv
`timescale 1ns/1ps
// Edge events of one synchronised encoder line
interface qcc_edge_if;
    logic level;  // Synchronised level
    logic rise;   // One-cycle rising pulse
    logic fall;   // One-cycle falling pulse
    modport src (output level, rise, fall);
    modport dst (input level, rise, fall);
endinterface

// ### qcc_sync_edge.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-flop synchroniser with edge detection
// ****************************************************************
module qcc_sync_edge (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pin,
    qcc_edge_if.src ev
);
    logic s1_reg, s2_reg, s3_reg;      // Sync chain and history
    logic s1_next, s2_next, s3_next;
    // Next values: pin feeds s1, s1 feeds s2, s2 feeds s3
    always_comb begin
        s1_next = pin;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end
    // Register the chain
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end
    assign ev.level = s2_reg;
    assign ev.rise = s2_reg & ~s3_reg;
    assign ev.fall = ~s2_reg & s3_reg;
endmodule // qcc_sync_edge

// ### qcc_top_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Bus and flag checks on the top ports
// ****************************************
module qcc_top_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    input wire logic position_match_flag,
    input wire logic shared_match_flag,
    input wire logic both_match_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic take;  // First access cycle
    logic clr;  // Status write with low lane
    assign take = psel && penable && !pready;
    assign clr = take && pwrite && paddr == qcc_pkg::QCC_STATUS_OFS && pstrb[0];
    // ****************************************
    // Properties
    // ****************************************
    property p_ready_once; pready |=> !pready; endproperty
    property p_one_wait; take |=> pready; endproperty
    property p_no_ready; !(psel && penable) |=> !pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_err_map; take && paddr > 8'h18 |=> pready && pslverr; endproperty
    property p_err_pos; take && pwrite && paddr == 8'h00 |=> pslverr; endproperty
    property p_err_lane;
        take && pwrite && pstrb[1:0] != 2'b11 && paddr != 8'h18 |=> pslverr;
    endproperty
    property p_pm_keep;
        position_match_flag && !(clr && pwdata[0]) |=> position_match_flag;
    endproperty
    property p_sm_keep;
        shared_match_flag && !(clr && pwdata[1]) |=> shared_match_flag;
    endproperty
    property p_bm_keep;
        both_match_flag && !(clr && pwdata[2]) |=> both_match_flag;
    endproperty
    property p_rst_flags;
        $fell(sys_rst) |-> !position_match_flag && !shared_match_flag && !both_match_flag;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    a_no_ready: assert property (p_no_ready) else $error("pready without access");
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    a_err_pos: assert property (p_err_pos) else $error("position write not refused");
    a_err_lane: assert property (p_err_lane) else $error("narrow write not refused");
    a_pm_keep: assert property (p_pm_keep) else $error("position flag lost");
    a_sm_keep: assert property (p_sm_keep) else $error("shared flag lost");
    a_bm_keep: assert property (p_bm_keep) else $error("both flag lost");
    a_rst_flags: assert property (p_rst_flags) else $error("flags set in reset");
    c_err: cover property (pready && pslverr);
    c_pm: cover property ($rose(position_match_flag));
    c_bm: cover property ($rose(both_match_flag));
endmodule // qcc_top_asserts
bind qcc_top qcc_top_asserts u_qcc_top_asserts (.ref_clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .phase_a_input,
    .phase_b_input, .index_input, .position_match_flag, .shared_match_flag, .both_match_flag);

// ### qcc_enc_model.sv
`timescale 1ns/1ps
// ****************************************
// Encoder model: phase and index lines
// ****************************************
module qcc_enc_model (
    input wire logic ref_clk,
    output logic phase_a_input,
    output logic phase_b_input,
    output logic index_input
);
    // All lines start low
    initial begin
        phase_a_input = 1'b0;
        phase_b_input = 1'b0;
        index_input = 1'b0;
    end
    // Toggle one line n times, leaving room for sync and count
    task automatic toggle(input int w, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (w == 0) phase_a_input <= ~phase_a_input;
            else if (w == 1) phase_b_input <= ~phase_b_input;
            else index_input <= ~index_input;
            repeat (8) @(posedge ref_clk);
        end
    endtask
endmodule // qcc_enc_model

// ### quadrature_counter_control_tb.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for the counter block
// ****************************************
module quadrature_counter_control_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic phase_a_input;
    logic phase_b_input;
    logic index_input;
    logic position_match_flag;
    logic shared_match_flag;
    logic both_match_flag;
    logic [31:0] rd;  // Last read data
    logic er;  // Last error answer
    logic [15:0] pos;  // Expected position
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    always #2 ref_clk = ~ref_clk;
    qcc_top u_qcc_top (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .phase_a_input, .phase_b_input, .index_input,
        .position_match_flag, .shared_match_flag, .both_match_flag);
    qcc_enc_model u_qcc_enc_model (.ref_clk, .phase_a_input, .phase_b_input, .index_input);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task conclude;
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask
    task automatic tg(input int w, input int n);
        u_qcc_enc_model.toggle(w, n);
    endtask
    task automatic flags(input logic [2:0] e);
        repeat (2) @(posedge ref_clk);
        chk({29'h0, position_match_flag, shared_match_flag, both_match_flag}, {29'h0, e});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0c, 32'h0);
        rdc(8'h10, 32'h0);
        rdc(8'h14, 32'hffff);
        bus(1'b0, 8'h1c, 32'h0, 4'hf);
        chk({31'h0, er}, 32'h1);
        bus(1'b1, 8'h00, 32'h5, 4'hf);
        chk({31'h0, er}, 32'h1);
        bus(1'b1, 8'h04, 32'h77, 4'h1);
        chk({31'h0, er}, 32'h1);
        rdc(8'h04, 32'h0);
    endtask
    task automatic t_rev;
        wr(8'h04, 32'h1234);
        rdc(8'h04, 32'h1234);
        wr(8'h04, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h04, 32'h55);
        wr(8'h10, 32'h0004);
        wr(8'h04, 32'h99);
        rdc(8'h04, 32'h55);
        wr(8'h10, 32'h0);
        wr(8'h04, 32'h0);
    endtask
    // Every A edge select, counting up in up-down mode
    task automatic t_edge;
        pos = 16'h0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, {22'h0, 2'(i), 8'h01});
            tg(0, 2);
            pos = pos + ((i == 3) ? 16'h2 : ((i == 0) ? 16'h0 : 16'h1));
            rdc(8'h00, {16'h0, pos});
        end
    endtask
    task automatic t_modes;
        wr(8'h10, 32'h0801);
        tg(1, 2);
        rdc(8'h00, 32'h3);
        wr(8'h10, 32'h0811);
        tg(1, 2);
        rdc(8'h00, 32'h3);
        wr(8'h10, 32'h0800);
        tg(1, 2);
        rdc(8'h00, 32'h3);
        wr(8'h10, 32'h0880);
        wr(8'h10, 32'h0881);
        tg(0, 2);
        rdc(8'h00, 32'h2);
        wr(8'h10, 32'h0880);
        wr(8'h10, 32'h0800);
        wr(8'h10, 32'h0f02);
        tg(0, 1);
        tg(1, 1);
        tg(0, 1);
        tg(1, 1);
        rdc(8'h00, 32'h6);
        wr(8'h10, 32'h0c03);
        tg(1, 2);
        rdc(8'h00, 32'h4);
        tg(0, 1);
        tg(1, 2);
        rdc(8'h00, 32'h6);
        tg(0, 1);
    endtask
    task automatic t_wrap;
        wr(8'h14, 32'h7);
        wr(8'h10, 32'h0c0b);
        tg(1, 7);
        rdc(8'h00, 32'h7);
        rdc(8'h04, 32'hffff);
        tg(0, 1);
        tg(1, 1);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
    endtask
    task automatic t_index;
        wr(8'h10, 32'h0);
        wr(8'h10, 32'h220d);
        tg(2, 2);
        rdc(8'h04, 32'h0);
        tg(0, 2);
        rdc(8'h00, 32'h1);
        tg(2, 2);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h1);
        wr(8'h10, 32'h2221);
        tg(0, 2);
        rdc(8'h00, 32'h0);
        tg(2, 1);
        tg(0, 2);
        rdc(8'h00, 32'h1);
        tg(2, 1);
    endtask
    task automatic t_cmp;
        wr(8'h10, 32'h0201);
        wr(8'h08, 32'h2);
        wr(8'h0c, 32'h2);
        wr(8'h18, 32'h7);
        flags(3'b000);
        tg(0, 2);
        flags(3'b110);
        wr(8'h0c, 32'h1);
        wr(8'h18, 32'h7);
        flags(3'b101);
        wr(8'h10, 32'h0241);
        flags(3'b111);
    endtask
    // Cycle ceiling against a hang
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            conclude();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rev();
        t_edge();
        t_modes();
        t_wrap();
        t_index();
        t_cmp();
        conclude();
    end
endmodule // quadrature_counter_control_tb
